// ==== rtl/ccs_top.sv ====
// Configuration register bank with serial slave and control pin setting select.
// Assumes pins are asynchronous to ref_clk_in and serial clock far below 40 MHz.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Every configuration byte except 00h is writable through the two-wire serial slave.
// - Generic bytes at 00h; PLL blocks at 10h, 20h, 30h.
// - Eight independently programmable control settings are held.
// - Setting index is {msb pin, mid pin, lsb pin}.
// - A setting holds primary state and per PLL frequency, spread, pair state.
// - Primary at 04h; PLL frequency x3h, spread x0h-x2h, pair x5h.
// - In serial mode mid and msb pins count as zero in the index.
// - Byte 02 bit 6 picks serial lines or control pins.
// - Each written byte takes effect as soon as it completes.
module ccs_top #(
    parameter logic [4:0] DEV_ADDR_HI = 5'h1B,
    parameter logic [7:0] ID_BYTE     = 8'h5A  // Arbitrary identity value
) (
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 select_pin_lsb_in,
    input  wire logic                 select_pin_mid_in,
    input  wire logic                 select_pin_msb_in,
    output logic                      select_pin_mid_out,
    output logic                      select_pin_mid_oe_out,
    output logic                      serial_mode_out,
    output ccs_pkg::ccs_setting_t     setting_out
);
    localparam int NP = ccs_pkg::CCS_NUM_PLL;

    // Pin synchronisers, three stages each
    logic [2:0] sync0_r;
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       pin0_f_r;
    logic       sda_f_r;
    logic       scl_f_r;
    logic       sda_d_r;
    logic       scl_d_r;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            sync0_r <= 3'h0;
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
        end else begin
            sync0_r <= {sync0_r[1:0], select_pin_lsb_in};
            sync1_r <= {sync1_r[1:0], select_pin_mid_in};
            sync2_r <= {sync2_r[1:0], select_pin_msb_in};
        end
    end

    // Accept a level only when stages two and three agree
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            pin0_f_r <= 1'b0;
            sda_f_r  <= 1'b1;
            scl_f_r  <= 1'b1;
            sda_d_r  <= 1'b1;
            scl_d_r  <= 1'b1;
        end else begin
            if (sync0_r[1] == sync0_r[2]) pin0_f_r <= sync0_r[2];
            if (sync1_r[1] == sync1_r[2]) sda_f_r  <= sync1_r[2];
            if (sync2_r[1] == sync2_r[2]) scl_f_r  <= sync2_r[2];
            sda_d_r <= sda_f_r;
            scl_d_r <= scl_f_r;
        end
    end

    // Mode bit and control terminal shadow copies
    logic                                       ctrl_mode_r;
    logic [7:0]                                 primary_r;
    logic [NP-1:0][7:0]                         freq_r;
    logic [NP-1:0][7:0]                         pair_r;
    logic [NP-1:0][ccs_pkg::CCS_SPREAD_W*8-1:0] spread_r;

    logic       wr_stb;
    logic [6:0] offs_r;
    logic [7:0] shift_r;

    assign serial_mode_out = !ctrl_mode_r;

    // Serial write path is closed while pins act as control inputs
    logic serial_en;
    assign serial_en = !ctrl_mode_r;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            ctrl_mode_r <= ccs_pkg::CCS_MODE_RST;
            primary_r   <= ccs_pkg::CCS_BYTE_RST;
        end else if (wr_stb) begin
            if (offs_r == ccs_pkg::CCS_MODE_OFFS) begin
                ctrl_mode_r <= shift_r[ccs_pkg::CCS_MODE_BIT];
            end else if (offs_r == ccs_pkg::CCS_PRIMARY_OFFS) begin
                primary_r <= shift_r;
            end
        end
    end

    logic [ccs_pkg::CCS_IDX_W-1:0] idx;
    // Dual pins read as zero while they carry serial traffic
    assign idx = ctrl_mode_r ? {scl_f_r, sda_f_r, pin0_f_r} : {2'b00, pin0_f_r};

    logic [6:0] pll_base [NP];
    assign pll_base[0] = ccs_pkg::CCS_PLL1_BASE;
    assign pll_base[1] = ccs_pkg::CCS_PLL2_BASE;
    assign pll_base[2] = ccs_pkg::CCS_PLL3_BASE;

    ccs_pkg::ccs_setting_t setting_nxt;
    assign setting_nxt.primary = primary_r[idx];

    genvar gp;
    generate
        for (gp = 0; gp < NP; gp++) begin : g_pll
            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    freq_r[gp]   <= ccs_pkg::CCS_BYTE_RST;
                    pair_r[gp]   <= ccs_pkg::CCS_BYTE_RST;
                    spread_r[gp] <= '0;
                end else if (wr_stb && offs_r[6:4] == pll_base[gp][6:4]) begin
                    if (offs_r[3:0] == ccs_pkg::CCS_FREQ_SUB) begin
                        freq_r[gp] <= shift_r;
                    end else if (offs_r[3:0] == ccs_pkg::CCS_PAIR_SUB) begin
                        pair_r[gp] <= shift_r;
                    end else if (offs_r[3:0] == ccs_pkg::CCS_SPREAD0_SUB) begin
                        spread_r[gp][7:0] <= shift_r;
                    end else if (offs_r[3:0] == ccs_pkg::CCS_SPREAD1_SUB) begin
                        spread_r[gp][15:8] <= shift_r;
                    end else if (offs_r[3:0] == ccs_pkg::CCS_SPREAD2_SUB) begin
                        spread_r[gp][23:16] <= shift_r;
                    end
                end
            end
            assign setting_nxt.pll[gp].freq   = freq_r[gp][idx];
            assign setting_nxt.pll[gp].pair   = pair_r[gp][idx];
            assign setting_nxt.pll[gp].spread = spread_r[gp][idx*ccs_pkg::CCS_SPREAD_W +: ccs_pkg::CCS_SPREAD_W];
        end
    endgenerate

    // Whole setting follows the index every cycle
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            setting_out <= '0;
        end else begin
            setting_out <= setting_nxt;
        end
    end

    // Serial slave
    ccs_pkg::ccs_state_t state_r;
    logic [3:0]          bitcnt_r;
    logic                rw_r;
    logic                drive_low_r;
    logic                mack_r;
    logic [7:0]          tx_r;
    logic [7:0]          mem_rd;
    logic [7:0]          rd_byte;

    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;
    assign start_ev = serial_en && scl_f_r && sda_d_r && !sda_f_r;
    assign stop_ev  = serial_en && scl_f_r && !sda_d_r && sda_f_r;
    assign scl_rise = serial_en && scl_f_r && !scl_d_r;
    assign scl_fall = serial_en && !scl_f_r && scl_d_r;

    logic addr_hit;
    assign addr_hit = (shift_r[7:1] == {DEV_ADDR_HI, 2'b00});

    // Byte 00h is read-only; nothing lives above 3Fh
    assign wr_stb = (state_r == ccs_pkg::CCS_WDATA) && scl_fall && (bitcnt_r == ccs_pkg::CCS_BITCNT_FULL)
                    && (offs_r != ccs_pkg::CCS_ID_OFFS) && (offs_r <= ccs_pkg::CCS_LAST_OFFS);

    always_comb begin
        if (offs_r == ccs_pkg::CCS_ID_OFFS) begin
            rd_byte = ID_BYTE;
        end else if (offs_r > ccs_pkg::CCS_LAST_OFFS) begin
            rd_byte = 8'h00;
        end else begin
            rd_byte = mem_rd;
        end
    end

    ccs_mem #(
        .WIDTH (ccs_pkg::CCS_DATA_W),
        .DEPTH (ccs_pkg::CCS_MEM_DEPTH),
        .AW    (6)
    ) u_mem (
        .ref_clk_in  (ref_clk_in),
        .wr_en_in    (wr_stb),
        .wr_addr_in  (offs_r[5:0]),
        .wr_data_in  (shift_r),
        .rd_addr_in  (offs_r[5:0]),
        .rd_data_out (mem_rd)
    );

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state_r     <= ccs_pkg::CCS_IDLE;
            bitcnt_r    <= 4'h0;
            rw_r        <= 1'b0;
            drive_low_r <= 1'b0;
            mack_r      <= 1'b0;
            shift_r     <= 8'h00;
            tx_r        <= 8'h00;
            offs_r      <= 7'h00;
        end else if (!serial_en || stop_ev) begin
            state_r     <= ccs_pkg::CCS_IDLE;
            drive_low_r <= 1'b0;
        end else if (start_ev) begin
            state_r     <= ccs_pkg::CCS_ADDR;
            bitcnt_r    <= 4'h0;
            drive_low_r <= 1'b0;
        end else if (scl_rise) begin
            shift_r  <= {shift_r[6:0], sda_f_r};
            bitcnt_r <= bitcnt_r + 4'h1;
            mack_r   <= !sda_f_r;
        end else if (scl_fall) begin
            case (state_r)
                ccs_pkg::CCS_ADDR: begin
                    if (bitcnt_r == ccs_pkg::CCS_BITCNT_FULL) begin
                        if (addr_hit) begin
                            rw_r        <= shift_r[0];
                            drive_low_r <= 1'b1;
                            state_r     <= ccs_pkg::CCS_ACK_ADDR;
                        end else begin
                            state_r <= ccs_pkg::CCS_IDLE;
                        end
                    end
                end
                ccs_pkg::CCS_ACK_ADDR: begin
                    bitcnt_r <= 4'h0;
                    if (rw_r) begin
                        tx_r        <= {rd_byte[6:0], 1'b0};
                        drive_low_r <= !rd_byte[7];
                        offs_r      <= offs_r + 7'h01;
                        state_r     <= ccs_pkg::CCS_RDATA;
                    end else begin
                        drive_low_r <= 1'b0;
                        state_r     <= ccs_pkg::CCS_CMD;
                    end
                end
                ccs_pkg::CCS_CMD: begin
                    if (bitcnt_r == ccs_pkg::CCS_BITCNT_FULL) begin
                        // Byte versus block only matters for stop placement here
                        offs_r      <= shift_r[6:0];
                        drive_low_r <= 1'b1;
                        state_r     <= ccs_pkg::CCS_ACK_CMD;
                    end
                end
                ccs_pkg::CCS_ACK_CMD, ccs_pkg::CCS_ACK_WDATA: begin
                    bitcnt_r    <= 4'h0;
                    drive_low_r <= 1'b0;
                    state_r     <= ccs_pkg::CCS_WDATA;
                end
                ccs_pkg::CCS_WDATA: begin
                    if (bitcnt_r == ccs_pkg::CCS_BITCNT_FULL) begin
                        offs_r      <= offs_r + 7'h01;
                        drive_low_r <= 1'b1;
                        state_r     <= ccs_pkg::CCS_ACK_WDATA;
                    end
                end
                ccs_pkg::CCS_RDATA: begin
                    if (bitcnt_r == ccs_pkg::CCS_BITCNT_FULL) begin
                        drive_low_r <= 1'b0;
                        state_r     <= ccs_pkg::CCS_RACK;
                    end else begin
                        drive_low_r <= !tx_r[7];
                        tx_r        <= {tx_r[6:0], 1'b0};
                    end
                end
                ccs_pkg::CCS_RACK: begin
                    bitcnt_r <= 4'h0;
                    if (mack_r) begin
                        tx_r        <= {rd_byte[6:0], 1'b0};
                        drive_low_r <= !rd_byte[7];
                        offs_r      <= offs_r + 7'h01;
                        state_r     <= ccs_pkg::CCS_RDATA;
                    end else begin
                        state_r <= ccs_pkg::CCS_IDLE;
                    end
                end
                default: begin
                    state_r <= ccs_pkg::CCS_IDLE;
                end
            endcase
        end
    end

    // Open-drain: only ever pulls low
    assign select_pin_mid_out    = 1'b0;
    assign select_pin_mid_oe_out = drive_low_r;

endmodule
`default_nettype wire

// ==== rtl/ccs_pkg.sv ====
// Constants and carrier types for the clock synth configuration select block.
// Assumes a single 40 MHz clock domain and a byte-wide configuration space.
package ccs_pkg;

    localparam int          CCS_DATA_W        = 8;
    localparam int          CCS_OFFS_W        = 7;
    localparam int          CCS_MEM_DEPTH     = 64;
    localparam int          CCS_NUM_PLL       = 3;
    localparam int          CCS_NUM_SET       = 8;
    localparam int          CCS_SPREAD_W      = 3;
    localparam int          CCS_IDX_W         = 3;

    // Register block bases and last offset
    localparam logic [6:0]  CCS_GENERIC_BASE  = 7'h00;
    localparam logic [6:0]  CCS_PLL1_BASE     = 7'h10;
    localparam logic [6:0]  CCS_PLL2_BASE     = 7'h20;
    localparam logic [6:0]  CCS_PLL3_BASE     = 7'h30;
    localparam logic [6:0]  CCS_LAST_OFFS     = 7'h3F;

    // Byte offsets and bit positions inside blocks
    localparam logic [6:0]  CCS_ID_OFFS       = 7'h00;
    localparam logic [6:0]  CCS_MODE_OFFS     = 7'h02;
    localparam logic [6:0]  CCS_PRIMARY_OFFS  = 7'h04;
    localparam logic [3:0]  CCS_SPREAD0_SUB   = 4'h0;
    localparam logic [3:0]  CCS_SPREAD1_SUB   = 4'h1;
    localparam logic [3:0]  CCS_SPREAD2_SUB   = 4'h2;
    localparam logic [3:0]  CCS_FREQ_SUB      = 4'h3;
    localparam logic [3:0]  CCS_PAIR_SUB      = 4'h5;
    localparam int          CCS_MODE_BIT      = 6;
    localparam int          CCS_CMD_BYTE_BIT  = 7;

    // Reset values and full bit count
    localparam logic [7:0]  CCS_BYTE_RST      = 8'h00;
    localparam logic        CCS_MODE_RST      = 1'b0;
    localparam logic [3:0]  CCS_BITCNT_FULL   = 4'h8;

    typedef struct packed {
        logic                     freq;
        logic [CCS_SPREAD_W-1:0]  spread;
        logic                     pair;
    } ccs_pll_sel_t;

    typedef struct packed {
        logic                             primary;
        ccs_pll_sel_t [CCS_NUM_PLL-1:0]   pll;
    } ccs_setting_t;

    typedef enum logic [3:0] {
        CCS_IDLE,
        CCS_ADDR,
        CCS_ACK_ADDR,
        CCS_CMD,
        CCS_ACK_CMD,
        CCS_WDATA,
        CCS_ACK_WDATA,
        CCS_RDATA,
        CCS_RACK
    } ccs_state_t;

endpackage

// ==== rtl/ccs_mem.sv ====
// Byte store mirroring the configuration space for serial readback.
// Assumes one write and one read port on the same clock; contents undefined until written.
`timescale 1ns/1ps
`default_nettype none
module ccs_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    input  wire logic             ref_clk_in,
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic [AW-1:0]    rd_addr_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    always_ff @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        rd_data_out <= mem_r[rd_addr_in];
    end
endmodule
`default_nettype wire

// ==== test/ccs_top_monitor.sv ====
// Port checker for ccs_top, bound to every instance.
// Assumes one clock domain and the hand-over timing of the serial slave.
`timescale 1ns/1ps
`default_nettype none
module ccs_top_monitor (
    input  wire logic                  ref_clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  select_pin_lsb_in,
    input  wire logic                  select_pin_mid_in,
    input  wire logic                  select_pin_msb_in,
    input  wire logic                  select_pin_mid_out,
    input  wire logic                  select_pin_mid_oe_out,
    input  wire logic                  serial_mode_out,
    input  wire ccs_pkg::ccs_setting_t setting_out
);
    logic [2:0] pins_r;
    logic [3:0] quiet_r;
    wire  logic [2:0] pins_now = {select_pin_msb_in, select_pin_mid_in, select_pin_lsb_in};
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Sync plus output flop fits well inside 15 quiet cycles
    always_ff @(posedge ref_clk_in) begin
        pins_r <= pins_now;
        if (!rst_n_in || pins_r != pins_now)
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hF)
            quiet_r <= quiet_r + 4'h1;
    end
    AST_RST_STATE: assert property ($rose(rst_n_in) |-> setting_out == '0 && serial_mode_out
        && !select_pin_mid_oe_out) else $error("reset state wrong");
    AST_MID_LOW: assert property (select_pin_mid_out == 1'b0)
        else $error("data line value not low");
    AST_QUIET_STABLE: assert property (quiet_r == 4'hF |-> $stable(setting_out))
        else $error("setting moved without cause");
    AST_MODE_STICKY: assert property (!$past(serial_mode_out) |-> !serial_mode_out)
        else $error("serial mode came back");
    AST_OE_HOLD: assert property ($rose(select_pin_mid_oe_out) |->
        (select_pin_mid_oe_out || !serial_mode_out) [*8]) else $error("data pull too short");
    AST_OE_RISE_SCL_LOW: assert property ($rose(select_pin_mid_oe_out) |-> !select_pin_msb_in)
        else $error("pull started with clock high");
    AST_OE_FALL_SCL_LOW: assert property ($fell(select_pin_mid_oe_out) |-> !select_pin_msb_in)
        else $error("pull ended with clock high");
    // Mode byte ack and mode switch share one edge, so look one cycle back
    AST_OE_SERIAL_ONLY: assert property ($rose(select_pin_mid_oe_out) |-> $past(serial_mode_out))
        else $error("pull in control mode");
    COV_ACK: cover property ($rose(select_pin_mid_oe_out));
    COV_MODE: cover property ($fell(serial_mode_out));
    COV_PIN_SEL: cover property (!serial_mode_out && $changed(setting_out));
endmodule
bind ccs_top ccs_top_monitor ccs_top_monitor_i (.ref_clk_in, .rst_n_in, .select_pin_lsb_in, .select_pin_mid_in,
    .select_pin_msb_in, .select_pin_mid_out, .select_pin_mid_oe_out, .serial_mode_out, .setting_out);
`default_nettype wire

// ==== test/ccs_host_model.sv ====
// Behavioural two-wire bus controller and control pin driver.
// Assumes the bench forms the pulled-up data line from all drivers.
`timescale 1ns/1ps
`default_nettype none
module ccs_host_model (
    input  wire logic ref_clk_in,
    input  wire logic sda_in,
    output logic      lsb_out,
    output logic      scl_out,
    output logic      sda_low_out
);
    initial begin
        lsb_out = 1'b0;
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // Quarter bit of 25 cycles, 400 kHz at most
    task automatic qtr();
        repeat (25) @(negedge ref_clk_in);
    endtask
    task automatic start();
        sda_low_out = 1'b0;
        qtr();
        scl_out = 1'b1;
        qtr();
        sda_low_out = 1'b1;
        qtr();
        scl_out = 1'b0;
        qtr();
    endtask
    task automatic stop();
        sda_low_out = 1'b1;
        qtr();
        scl_out = 1'b1;
        qtr();
        sda_low_out = 1'b0;
        qtr();
    endtask
    // Data only moves a quarter after the clock fell
    task automatic bitx(input logic b, output logic r);
        sda_low_out = !b;
        qtr();
        scl_out = 1'b1;
        qtr();
        r = sda_in;
        qtr();
        scl_out = 1'b0;
        qtr();
    endtask
    // One byte each way, 8'hFF releases the line for reads
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(ack_in, ack);
    endtask
    task automatic set_pins(input logic [2:0] k);
        lsb_out = k[0];
        sda_low_out = !k[1];
        scl_out = k[2];
    endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for ccs_top over the two-wire bus and control pins.
// Assumes the host model moves pins only after falling clock edges.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
    localparam logic [7:0] ID_VAL = 8'h5A;  // Arbitrary identity value
    localparam logic [7:0] ADDR_W = 8'hD8;
    logic                  ref_clk_in, rst_n_in, lsb, scl, sda_low, mid_out, oe, ser_mode;
    ccs_pkg::ccs_setting_t set_out;
    logic [7:0]            cfg [0:63];
    int                    mismatches, tests_run;
    int                    cyc = 0;
    wire logic             sda_lvl = !(sda_low || oe);
    ccs_top #(.DEV_ADDR_HI(5'h1B), .ID_BYTE(ID_VAL)) ccs_top_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .select_pin_lsb_in(lsb), .select_pin_mid_in(sda_lvl), .select_pin_msb_in(scl), .select_pin_mid_out(mid_out),
        .select_pin_mid_oe_out(oe), .serial_mode_out(ser_mode), .setting_out(set_out));
    ccs_host_model ccs_host_model_i (.ref_clk_in(ref_clk_in), .sda_in(sda_lvl), .lsb_out(lsb), .scl_out(scl),
        .sda_low_out(sda_low));
    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = !ref_clk_in;
    end
    function automatic ccs_pkg::ccs_setting_t exp_set(input logic [2:0] k);
        ccs_pkg::ccs_setting_t s;
        logic [23:0]           sp;
        s.primary = cfg[4][k];
        for (int p = 0; p < 3; p++) begin
            sp = {cfg[16*p+18], cfg[16*p+17], cfg[16*p+16]};
            s.pll[p].freq = cfg[16*p+19][k];
            s.pll[p].spread = sp[3*k+:3];
            s.pll[p].pair = cfg[16*p+21][k];
        end
        return s;
    endfunction
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic [7:0] r;
        logic       a;
        ccs_host_model_i.xfer(d, 1'b1, r, a);
        `CHK(a, !exp_ack)
    endtask
    task automatic wr(input logic [6:0] off, input int n);
        ccs_host_model_i.start();
        send(ADDR_W, 1'b1);
        send({1'b0, off}, 1'b1);
        for (int i = 0; i < n; i++) send(cfg[off+i], 1'b1);
        ccs_host_model_i.stop();
    endtask
    task automatic rd(input logic [6:0] off, input logic [7:0] exp);
        logic [7:0] r;
        logic       a;
        ccs_host_model_i.start();
        send(ADDR_W, 1'b1);
        send({1'b0, off}, 1'b1);
        ccs_host_model_i.start();
        send(ADDR_W | 8'h01, 1'b1);
        ccs_host_model_i.xfer(8'hFF, 1'b1, r, a);
        ccs_host_model_i.stop();
        `CHK(r, exp)
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Budget of 60k cycles for a whole run of near 50k
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        logic [7:0] rb;
        logic       ab;
        rst_n_in = 1'b0;
        mismatches = 0;
        tests_run = 0;
        for (int i = 0; i < 64; i++) cfg[i] = 8'(i * 8'h1D) ^ 8'hA6;
        repeat (3) @(negedge ref_clk_in);
        rst_n_in = 1'b1;
        repeat (8) @(negedge ref_clk_in);
        `CHK(set_out, '0)
        `CHK(ser_mode, 1'b1)
        wr(7'h04, 1);
        for (int p = 1; p < 4; p++) wr(7'(16*p), 6);
        // Idle serial lines sit high, so the index must ignore them
        for (int k = 0; k < 2; k++) begin
            ccs_host_model_i.set_pins({2'b11, k[0]});
            repeat (15) @(negedge ref_clk_in);
            `CHK(set_out, exp_set({2'b00, k[0]}))
        end
        $display("test serial_select done");
        rd(7'h13, cfg[19]);
        rd(7'h35, cfg[53]);
        rd(7'h00, ID_VAL);
        rd(7'h40, 8'h00);
        // Two-byte read with master ack walks the offset forward
        ccs_host_model_i.start();
        send(ADDR_W, 1'b1);
        send(8'h24, 1'b1);
        ccs_host_model_i.start();
        send(ADDR_W | 8'h01, 1'b1);
        ccs_host_model_i.xfer(8'hFF, 1'b0, rb, ab);
        `CHK(rb, cfg[36])
        ccs_host_model_i.xfer(8'hFF, 1'b1, rb, ab);
        `CHK(rb, cfg[37])
        ccs_host_model_i.stop();
        ccs_host_model_i.start();
        send(8'hA0, 1'b0);
        ccs_host_model_i.stop();
        $display("test readback done");
        // Serial access is gone after this byte until reset
        cfg[2] = 8'h40;
        ccs_host_model_i.start();
        send(ADDR_W, 1'b1);
        send(8'h02, 1'b1);
        ccs_host_model_i.xfer(cfg[2], 1'b1, rb, ab);
        ccs_host_model_i.stop();
        repeat (15) @(negedge ref_clk_in);
        `CHK(ser_mode, 1'b0)
        for (int k = 0; k < 8; k++) begin
            ccs_host_model_i.set_pins(3'(k * 5));
            repeat (15) @(negedge ref_clk_in);
            `CHK(set_out, exp_set(3'(k * 5)))
        end
        $display("test control_select done");
        complete_run();
    end
endmodule
`default_nettype wire
